// >>> core/dagu_regs.svh
`ifndef DAGU_REGS_SVH
`define DAGU_REGS_SVH
`define DAGU_AW 24
`define DAGU_MOD_LINEAR 24'hFFFFFF
`define DAGU_MOD_REV 24'h000000
`define DAGU_MOD_MWRAP_BIT 15
`define DAGU_SC_HI_LSB 16
`define DAGU_SC_SIGN_BIT 15
`define DAGU_SC_DELAY 2'h3
`define DAGU_REG_PTR 2'h0
`define DAGU_REG_OFS 2'h1
`define DAGU_REG_MOD 2'h2
`define DAGU_REG_SEP 2'h3
`endif

// >>> core/dagu_pkg.sv
package dagu_pkg;
	typedef enum logic [2:0] {
		DAGU_UPD_NONE = 3'h0,
		DAGU_UPD_INC = 3'h1,
		DAGU_UPD_DEC = 3'h2,
		DAGU_UPD_ADDN = 3'h3,
		DAGU_UPD_SUBN = 3'h4,
		DAGU_UPD_INDEX = 3'h5,
		DAGU_UPD_PREDEC = 3'h6,
		DAGU_UPD_DISP = 3'h7
	} dagu_mode_t;
	typedef enum logic [1:0] {
		DAGU_BUS_NONE = 2'h0,
		DAGU_BUS_P = 2'h1,
		DAGU_BUS_X = 2'h2,
		DAGU_BUS_Y = 2'h3
	} dagu_bus_t;
	typedef enum logic [1:0] {
		DAGU_ARITH_LINEAR = 2'h0,
		DAGU_ARITH_MODULO = 2'h1,
		DAGU_ARITH_MWRAP = 2'h3,
		DAGU_ARITH_REVERSE = 2'h2
	} dagu_arith_t;
endpackage

// >>> core/dagu_unit_if.sv
`timescale 1ns/1ps
interface dagu_unit_if;
	logic req;
	logic [1:0] idx;
	dagu_pkg::dagu_mode_t mode;
	logic [23:0] disp;
	logic sc;
	logic [23:0] ptr;
	logic [23:0] ofs;
	logic [23:0] modv;
	logic [23:0] ea;
	logic [23:0] upd;
	logic wr;
	modport top (output req, idx, mode, disp, sc, ptr, ofs, modv, input ea, upd, wr);
	modport alu (input req, idx, mode, disp, sc, ptr, ofs, modv, output ea, upd, wr);
endinterface

// >>> core/dagu_alu.sv
`timescale 1ns/1ps
`include "dagu_regs.svh"
// one address arithmetic unit, purely combinational
module dagu_alu (
	dagu_unit_if.alu u
);
	// bit reverse helper for the reverse-carry adder
	function automatic logic [23:0] dagu_rev(input logic [23:0] v);
		logic [23:0] r;
		r = '0;
		for (int i = 0; i < 24; i++) begin
			r[i] = v[23 - i];
		end
		return r;
	endfunction

	// ones from the top set bit downward; shifts must chain or the mask has holes
	function automatic logic [23:0] dagu_smear(input logic [23:0] m);
		logic [23:0] s;
		s = m;
		s = s | (s >> 1);
		s = s | (s >> 2);
		s = s | (s >> 4);
		s = s | (s >> 8);
		s = s | (s >> 16);
		return s;
	endfunction

	// modifier decode: linear, reverse-carry, multiple-wrap or plain modulo
	function automatic dagu_pkg::dagu_arith_t dagu_decode(input logic [23:0] m);
		if (m == `DAGU_MOD_LINEAR) begin
			return dagu_pkg::DAGU_ARITH_LINEAR;
		end else if (m == `DAGU_MOD_REV) begin
			return dagu_pkg::DAGU_ARITH_REVERSE;
		end else if (m[`DAGU_MOD_MWRAP_BIT]) begin
			return dagu_pkg::DAGU_ARITH_MWRAP;
		end else begin
			return dagu_pkg::DAGU_ARITH_MODULO;
		end
	endfunction

	logic [23:0] ofs_ext, step, sum, rsum, msum, base, lo, hi, mask, res, top;
	logic [23:0] modulus;
	dagu_pkg::dagu_arith_t arith;
	logic neg;

	// step selection; sign of the offset from bit 15 in compat mode
	always_comb begin
		ofs_ext = u.sc ? {{8{u.ofs[`DAGU_SC_SIGN_BIT]}}, u.ofs[15:0]} : u.ofs;
		neg = 1'b0;
		case (u.mode)
			dagu_pkg::DAGU_UPD_INC: step = 24'h000001;
			dagu_pkg::DAGU_UPD_DEC, dagu_pkg::DAGU_UPD_PREDEC: begin
				step = 24'hFFFFFF;
				neg = 1'b1;
			end
			dagu_pkg::DAGU_UPD_ADDN: begin
				step = ofs_ext;
				neg = ofs_ext[23];
			end
			dagu_pkg::DAGU_UPD_SUBN: begin
				step = 24'(-ofs_ext);
				neg = ~ofs_ext[23];
			end
			default: step = 24'h000000;
		endcase
	end

	// offset and reverse-carry adders share inputs and run in parallel
	assign arith = dagu_decode(u.modv);
	assign modulus = 24'(u.modv + 24'h000001);
	assign sum = 24'(u.ptr + step);
	assign rsum = dagu_rev(24'(dagu_rev(u.ptr) + dagu_rev(step)));
	assign mask = dagu_smear(u.modv);
	assign lo = u.ptr & ~mask;
	assign hi = 24'(lo + u.modv);

	// modulo adder: wraps by plus or minus the modulus; the mask keeps the
	// wrap test cheap at the cost of needing an aligned base
	always_comb begin
		msum = sum;
		if (!neg && sum > hi) begin
			msum = 24'(sum - modulus);
		end else if (neg && sum < lo) begin
			msum = 24'(sum + modulus);
		end
	end

	// result selection among the three adders
	always_comb begin
		case (arith)
			dagu_pkg::DAGU_ARITH_REVERSE: res = rsum;
			dagu_pkg::DAGU_ARITH_MODULO: res = msum;
			dagu_pkg::DAGU_ARITH_MWRAP: res = (u.ptr & ~mask) | (sum & mask);
			default: res = sum;
		endcase
		top = res;
		if (u.sc) begin
			top = {8'h00, res[15:0]};
		end
	end

	// effective address and write-back per mode
	always_comb begin
		base = u.ptr;
		case (u.mode)
			dagu_pkg::DAGU_UPD_INDEX: base = 24'(u.ptr + ofs_ext);
			dagu_pkg::DAGU_UPD_DISP: base = 24'(u.ptr + u.disp);
			dagu_pkg::DAGU_UPD_PREDEC: base = top;
			default: base = u.ptr;
		endcase
		u.ea = u.sc ? {8'h00, base[15:0]} : base;
		u.upd = top;
		u.wr = u.req && (u.mode inside {dagu_pkg::DAGU_UPD_INC, dagu_pkg::DAGU_UPD_DEC,
			dagu_pkg::DAGU_UPD_ADDN, dagu_pkg::DAGU_UPD_SUBN, dagu_pkg::DAGU_UPD_PREDEC});
	end
endmodule

// >>> core/dagu_top.sv
`timescale 1ns/1ps
`include "dagu_regs.svh"
module dagu_top (
	input wire logic I_REF_CLK,
	input wire logic I_RST_B,
	input wire logic I_ICYC_EN,
	input wire logic I_SC_MODE,
	input wire logic I_STACK_MEM_SEL,
	input wire logic I_LO_REQ,
	input wire logic [1:0] I_LO_IDX,
	input wire logic [2:0] I_LO_MODE,
	input wire logic [6:0] I_LO_DISP,
	input wire logic [1:0] I_LO_BUS,
	input wire logic I_HI_REQ,
	input wire logic [1:0] I_HI_IDX,
	input wire logic [2:0] I_HI_MODE,
	input wire logic [6:0] I_HI_DISP,
	input wire logic [1:0] I_HI_BUS,
	input wire logic I_GDP_WR,
	input wire logic [1:0] I_GDP_KIND,
	input wire logic [2:0] I_GDP_IDX,
	input wire logic [23:0] I_GDP_WDATA,
	input wire logic [1:0] I_SEP_OP,
	output logic [23:0] O_GDP_RDATA,
	output logic [23:0] O_PROGRAM_ADDR_BUS,
	output logic O_PROGRAM_ADDR_VALID,
	output logic [23:0] O_XMEM_ADDR_BUS,
	output logic O_XMEM_ADDR_VALID,
	output logic [23:0] O_YMEM_ADDR_BUS,
	output logic O_YMEM_ADDR_VALID,
	output logic O_SC_ACTIVE,
	output logic O_STACK_IN_Y,
	output logic [23:0] O_STACK_ADDR
);
	logic [23:0] addr_pointer_q [8];
	logic [23:0] step_offset_q [8];
	logic [23:0] arith_modifier_q [8];
	logic [23:0] stack_ext_pointer_q;
	logic [2:0] sc_pipe_q;
	logic sc_q;
	logic [23:0] wdata;
	logic [2:0] lo_sel, hi_sel;

	dagu_unit_if lo_u ();
	dagu_unit_if hi_u ();

	// compat bit seen by the datapath only after a three-cycle pipe
	always_ff @(posedge I_REF_CLK) begin
		if (!I_RST_B) begin
			sc_pipe_q <= 3'h0;
		end else if (I_ICYC_EN) begin
			sc_pipe_q <= {sc_pipe_q[1:0], I_SC_MODE};
		end
	end
	assign sc_q = sc_pipe_q[2];

	// low unit owns triplets 0-3, high unit 4-7
	assign lo_sel = {1'b0, I_LO_IDX};
	assign hi_sel = {1'b1, I_HI_IDX};

	assign lo_u.req = I_LO_REQ & I_ICYC_EN;
	assign lo_u.idx = I_LO_IDX;
	assign lo_u.mode = dagu_pkg::dagu_mode_t'(I_LO_MODE);
	assign lo_u.disp = sc_q ? {8'h00, {9{I_LO_DISP[6]}}, I_LO_DISP} : {{17{I_LO_DISP[6]}}, I_LO_DISP};
	assign lo_u.sc = sc_q;
	assign lo_u.ptr = addr_pointer_q[lo_sel];
	assign lo_u.ofs = step_offset_q[lo_sel];
	assign lo_u.modv = arith_modifier_q[lo_sel];

	assign hi_u.req = I_HI_REQ & I_ICYC_EN;
	assign hi_u.idx = I_HI_IDX;
	assign hi_u.mode = dagu_pkg::dagu_mode_t'(I_HI_MODE);
	assign hi_u.disp = sc_q ? {8'h00, {9{I_HI_DISP[6]}}, I_HI_DISP} : {{17{I_HI_DISP[6]}}, I_HI_DISP};
	assign hi_u.sc = sc_q;
	assign hi_u.ptr = addr_pointer_q[hi_sel];
	assign hi_u.ofs = step_offset_q[hi_sel];
	assign hi_u.modv = arith_modifier_q[hi_sel];

	dagu_alu u_lo (
		.u(lo_u)
	);
	dagu_alu u_hi (
		.u(hi_u)
	);

	// moves to pointer, offset and modifier registers in compat mode clear the destination top byte
	assign wdata = sc_q ? {8'h00, I_GDP_WDATA[15:0]} : I_GDP_WDATA;

	// pointer files: one read-modify-write per unit per cycle; a data-path
	// write to the same pointer wins since it is the later instruction
	always_ff @(posedge I_REF_CLK) begin
		for (int i = 0; i < 8; i++) begin
			if (I_ICYC_EN && I_GDP_WR && I_GDP_KIND == `DAGU_REG_PTR && I_GDP_IDX == 3'(i)) begin
				addr_pointer_q[i] <= wdata;
			end else if (lo_u.wr && lo_sel == 3'(i)) begin
				addr_pointer_q[i] <= lo_u.upd;
			end else if (hi_u.wr && hi_sel == 3'(i)) begin
				addr_pointer_q[i] <= hi_u.upd;
			end
		end
	end

	// offset registers, plain storage when not used as step
	always_ff @(posedge I_REF_CLK) begin
		for (int i = 0; i < 8; i++) begin
			if (I_ICYC_EN && I_GDP_WR && I_GDP_KIND == `DAGU_REG_OFS && I_GDP_IDX == 3'(i)) begin
				step_offset_q[i] <= wdata;
			end
		end
	end

	// modifiers reset to linear arithmetic
	always_ff @(posedge I_REF_CLK) begin
		for (int i = 0; i < 8; i++) begin
			if (!I_RST_B) begin
				arith_modifier_q[i] <= `DAGU_MOD_LINEAR;
			end else if (I_ICYC_EN && I_GDP_WR && I_GDP_KIND == `DAGU_REG_MOD && I_GDP_IDX == 3'(i)) begin
				arith_modifier_q[i] <= wdata;
			end
		end
	end

	// stack extension pointer: deliberately no reset, software loads it;
	// op 1 is a push, op 2 a pull
	always_ff @(posedge I_REF_CLK) begin
		if (I_ICYC_EN && I_GDP_WR && I_GDP_KIND == `DAGU_REG_SEP) begin
			stack_ext_pointer_q <= I_GDP_WDATA;
		end else if (I_ICYC_EN && I_SEP_OP == 2'h1) begin
			stack_ext_pointer_q <= 24'(stack_ext_pointer_q + 24'h000001);
		end else if (I_ICYC_EN && I_SEP_OP == 2'h2) begin
			stack_ext_pointer_q <= 24'(stack_ext_pointer_q - 24'h000001);
		end
	end

	// data path read mux, registered
	always_ff @(posedge I_REF_CLK) begin
		if (!I_RST_B) begin
			O_GDP_RDATA <= 24'h000000;
		end else begin
			case (I_GDP_KIND)
				`DAGU_REG_PTR: O_GDP_RDATA <= sc_q ? {8'h00, addr_pointer_q[I_GDP_IDX][15:0]}
					: addr_pointer_q[I_GDP_IDX];
				`DAGU_REG_OFS: O_GDP_RDATA <= sc_q ? {8'h00, step_offset_q[I_GDP_IDX][15:0]}
					: step_offset_q[I_GDP_IDX];
				`DAGU_REG_MOD: O_GDP_RDATA <= sc_q ? {8'h00, arith_modifier_q[I_GDP_IDX][15:0]}
					: arith_modifier_q[I_GDP_IDX];
				default: O_GDP_RDATA <= stack_ext_pointer_q;
			endcase
		end
	end

	// address muxes: program bus only alone, otherwise X and Y from either
	// unit; a P request from the low unit suppresses any high-unit address
	always_ff @(posedge I_REF_CLK) begin
		if (!I_RST_B) begin
			O_PROGRAM_ADDR_BUS <= 24'h000000;
			O_PROGRAM_ADDR_VALID <= 1'b0;
			O_XMEM_ADDR_BUS <= 24'h000000;
			O_XMEM_ADDR_VALID <= 1'b0;
			O_YMEM_ADDR_BUS <= 24'h000000;
			O_YMEM_ADDR_VALID <= 1'b0;
		end else begin
			O_PROGRAM_ADDR_VALID <= 1'b0;
			O_XMEM_ADDR_VALID <= 1'b0;
			O_YMEM_ADDR_VALID <= 1'b0;
			if (lo_u.req && I_LO_BUS == dagu_pkg::DAGU_BUS_P) begin
				O_PROGRAM_ADDR_BUS <= lo_u.ea;
				O_PROGRAM_ADDR_VALID <= 1'b1;
			end else if (hi_u.req && I_HI_BUS == dagu_pkg::DAGU_BUS_P && !lo_u.req) begin
				O_PROGRAM_ADDR_BUS <= hi_u.ea;
				O_PROGRAM_ADDR_VALID <= 1'b1;
			end else begin
				if (lo_u.req && I_LO_BUS == dagu_pkg::DAGU_BUS_X) begin
					O_XMEM_ADDR_BUS <= lo_u.ea;
					O_XMEM_ADDR_VALID <= 1'b1;
				end else if (hi_u.req && I_HI_BUS == dagu_pkg::DAGU_BUS_X) begin
					O_XMEM_ADDR_BUS <= hi_u.ea;
					O_XMEM_ADDR_VALID <= 1'b1;
				end
				if (hi_u.req && I_HI_BUS == dagu_pkg::DAGU_BUS_Y) begin
					O_YMEM_ADDR_BUS <= hi_u.ea;
					O_YMEM_ADDR_VALID <= 1'b1;
				end else if (lo_u.req && I_LO_BUS == dagu_pkg::DAGU_BUS_Y) begin
					O_YMEM_ADDR_BUS <= lo_u.ea;
					O_YMEM_ADDR_VALID <= 1'b1;
				end
			end
		end
	end

	// status and stack placement, registered
	always_ff @(posedge I_REF_CLK) begin
		if (!I_RST_B) begin
			O_SC_ACTIVE <= 1'b0;
			O_STACK_IN_Y <= 1'b0;
			O_STACK_ADDR <= 24'h000000;
		end else begin
			O_SC_ACTIVE <= sc_q;
			O_STACK_IN_Y <= I_STACK_MEM_SEL;
			O_STACK_ADDR <= sc_q ? {8'h00, stack_ext_pointer_q[15:0]} : stack_ext_pointer_q;
		end
	end
endmodule

// >>> test/dagu_top_monitor.sv
`timescale 1ns/1ps
module dagu_top_monitor (
	input wire logic I_REF_CLK,
	input wire logic I_RST_B,
	input wire logic I_ICYC_EN,
	input wire logic I_STACK_MEM_SEL,
	input wire logic I_LO_REQ,
	input wire logic [1:0] I_LO_BUS,
	input wire logic I_HI_REQ,
	input wire logic [1:0] I_HI_BUS,
	input wire logic [23:0] O_GDP_RDATA,
	input wire logic O_PROGRAM_ADDR_VALID,
	input wire logic O_XMEM_ADDR_VALID,
	input wire logic [23:0] O_YMEM_ADDR_BUS,
	input wire logic O_YMEM_ADDR_VALID,
	input wire logic O_SC_ACTIVE,
	input wire logic O_STACK_IN_Y
);
	logic any_v;
	// any address strobe this cycle
	assign any_v = O_PROGRAM_ADDR_VALID | O_XMEM_ADDR_VALID | O_YMEM_ADDR_VALID;
	default clocking cb @(posedge I_REF_CLK); endclocking
	default disable iff (!I_RST_B);
	// at most two addresses, never a fetch beside data
	property p_pair; !(O_PROGRAM_ADDR_VALID && (O_XMEM_ADDR_VALID || O_YMEM_ADDR_VALID)); endproperty
	a_pair: assert property (p_pair) else $error("fetch and data address together");
	property p_cause; any_v |-> $past(I_ICYC_EN && (I_LO_REQ || I_HI_REQ)); endproperty
	a_cause: assert property (p_cause) else $error("address without request");
	property p_pfirst; I_ICYC_EN && I_LO_REQ && I_LO_BUS == 2'h1
		|=> O_PROGRAM_ADDR_VALID && !O_XMEM_ADDR_VALID && !O_YMEM_ADDR_VALID; endproperty
	a_pfirst: assert property (p_pfirst) else $error("fetch not exclusive");
	property p_dual; I_ICYC_EN && I_LO_REQ && I_LO_BUS == 2'h2 && I_HI_REQ && I_HI_BUS == 2'h3
		|=> O_XMEM_ADDR_VALID && O_YMEM_ADDR_VALID; endproperty
	a_dual: assert property (p_dual) else $error("dual move lost an address");
	// compat pipe only advances on instruction cycles; the flag lags the pipe by one edge
	property p_scgate; $changed(O_SC_ACTIVE) |-> $past(I_ICYC_EN, 2); endproperty
	a_scgate: assert property (p_scgate) else $error("compat changed off cycle");
	property p_scaddr; O_SC_ACTIVE && $past(O_SC_ACTIVE) && O_YMEM_ADDR_VALID
		|-> O_YMEM_ADDR_BUS[23:16] == 8'h00; endproperty
	a_scaddr: assert property (p_scaddr) else $error("compat address top byte set");
	property p_scread; O_SC_ACTIVE && $past(O_SC_ACTIVE) |-> O_GDP_RDATA[23:16] == 8'h00; endproperty
	a_scread: assert property (p_scread) else $error("compat read top byte set");
	property p_stack; $past(I_RST_B && I_ICYC_EN) |-> O_STACK_IN_Y == $past(I_STACK_MEM_SEL); endproperty
	a_stack: assert property (p_stack) else $error("stack memory select wrong");
endmodule
bind dagu_top dagu_top_monitor dagu_top_monitor_inst (.I_REF_CLK(I_REF_CLK), .I_RST_B(I_RST_B),
	.I_ICYC_EN(I_ICYC_EN), .I_STACK_MEM_SEL(I_STACK_MEM_SEL), .I_LO_REQ(I_LO_REQ), .I_LO_BUS(I_LO_BUS),
	.I_HI_REQ(I_HI_REQ), .I_HI_BUS(I_HI_BUS), .O_GDP_RDATA(O_GDP_RDATA),
	.O_PROGRAM_ADDR_VALID(O_PROGRAM_ADDR_VALID), .O_XMEM_ADDR_VALID(O_XMEM_ADDR_VALID),
	.O_YMEM_ADDR_BUS(O_YMEM_ADDR_BUS), .O_YMEM_ADDR_VALID(O_YMEM_ADDR_VALID),
	.O_SC_ACTIVE(O_SC_ACTIVE), .O_STACK_IN_Y(O_STACK_IN_Y));

// >>> test/dagu_pcu_model.sv
`timescale 1ns/1ps
module dagu_pcu_model (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic slow,
	output logic icyc_en
);
	// slow mode stretches each instruction over two clocks, like wait states
	always @(posedge clk) begin
		icyc_en <= (rst_b && slow) ? !icyc_en : 1'h1;
	end
endmodule

// >>> test/tb.sv
`timescale 1ns/1ps
module tb;
	logic clk, rst_b, en, slow, sc, ssel, lreq, hreq, wr, pv, xv, yv, sca, siy;
	logic [1:0] lidx, hidx, lbus, hbus, kind, sop;
	logic [2:0] lmode, hmode, gidx, x;
	logic [6:0] ldisp, hdisp, d;
	logic [23:0] wdata, rd, program_addr_bus, xmem_addr_bus, ymem_addr_bus, sad, r, n, s, e;
	int fail_count, samples_checked, cyc, i, k;
	dagu_pcu_model dagu_pcu_model_inst (.clk(clk), .rst_b(rst_b), .slow(slow), .icyc_en(en));
	dagu_top dagu_top_inst (.I_REF_CLK(clk), .I_RST_B(rst_b), .I_ICYC_EN(en), .I_SC_MODE(sc),
		.I_STACK_MEM_SEL(ssel), .I_LO_REQ(lreq), .I_LO_IDX(lidx), .I_LO_MODE(lmode), .I_LO_DISP(ldisp),
		.I_LO_BUS(lbus), .I_HI_REQ(hreq), .I_HI_IDX(hidx), .I_HI_MODE(hmode), .I_HI_DISP(hdisp),
		.I_HI_BUS(hbus), .I_GDP_WR(wr), .I_GDP_KIND(kind), .I_GDP_IDX(gidx), .I_GDP_WDATA(wdata),
		.I_SEP_OP(sop), .O_GDP_RDATA(rd), .O_PROGRAM_ADDR_BUS(program_addr_bus), .O_PROGRAM_ADDR_VALID(pv),
		.O_XMEM_ADDR_BUS(xmem_addr_bus), .O_XMEM_ADDR_VALID(xv), .O_YMEM_ADDR_BUS(ymem_addr_bus), .O_YMEM_ADDR_VALID(yv),
		.O_SC_ACTIVE(sca), .O_STACK_IN_Y(siy), .O_STACK_ADDR(sad));
	// reference clock
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	// watchdog; the whole sequence needs well under a thousand cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc > 3000) begin
			fail_count++;
			close_out;
		end
	end
	task chk(input logic [23:0] got, input logic [23:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task tick;
		@(posedge clk);
		#1;
	endtask
	// writes hold the strobe until the next call clears it, so no double drive per step
	task wreg(input logic [1:0] k2, input logic [2:0] ix, input logic [23:0] dv);
		{lreq, hreq, wr, kind, gidx, wdata} = {3'h1, k2, ix, dv};
		tick;
	endtask
	task rreg(input logic [1:0] k2, input logic [2:0] ix, output logic [23:0] v);
		{lreq, hreq, wr, kind, gidx} = {3'h0, k2, ix};
		tick;
		v = rd;
	endtask
	task req(input logic h, input logic [1:0] ix, input logic [2:0] md, input logic [6:0] dp, input logic [1:0] b);
		if (h) {hreq, hidx, hmode, hdisp, hbus} = {1'h1, ix, md, dp, b};
		else {lreq, lidx, lmode, ldisp, lbus} = {1'h1, ix, md, dp, b};
		wr = 1'h0;
	endtask
	task close_out;
		$display("comparisons %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	function logic [23:0] rev(input logic [23:0] a);
		for (int j = 0; j < 24; j++) rev[j] = a[23 - j];
	endfunction
	// signed step each mode applies
	function logic [23:0] step(input logic [2:0] md, input logic [23:0] nv, input logic [6:0] dp);
		case (md)
			3'h1: step = 24'h000001;
			3'h2, 3'h6: step = 24'hFFFFFF;
			3'h3, 3'h5: step = nv;
			3'h4: step = -nv;
			3'h7: step = {{17{dp[6]}}, dp};
			default: step = 24'h000000;
		endcase
	endfunction
	// main sequence
	initial begin
		{rst_b, slow, sc, ssel, lreq, hreq, wr, sop, kind, gidx, wdata} = '0;
		{lidx, lmode, ldisp, lbus, hidx, hmode, hdisp, hbus} = '0;
		void'($urandom(68782));
		repeat (4) @(posedge clk);
		#1 rst_b = 1'h1;
		chk({21'h0, pv, xv, yv}, 24'h0);
		for (i = 0; i < 8; i++) begin
			rreg(2'h2, 3'(i), e);
			chk(e, 24'hFFFFFF);
		end
		// random linear accesses over every mode and both halves
		for (i = 0; i < 32; i++) begin
			x = 3'($urandom);
			r = 24'($urandom);
			n = 24'($urandom);
			d = 7'($urandom);
			k = i % 8;
			wreg(2'h0, x, r);
			wreg(2'h1, x, n);
			req(x[2], x[1:0], 3'(k), d, {1'h1, x[2]});
			tick;
			s = step(3'(k), n, d);
			chk(x[2] ? ymem_addr_bus : xmem_addr_bus, (k > 4) ? r + s : r);
			chk({23'h0, x[2] ? yv : xv}, 24'h1);
			rreg(2'h0, x, e);
			chk(e, (k == 5 || k == 7) ? r : r + s);
			rreg(2'h1, x, e);
			chk(e, n);
		end
		// dual move, then a low-half fetch that blocks the high half
		wreg(2'h0, 3'h1, 24'h123456);
		wreg(2'h0, 3'h6, 24'h654321);
		req(1'h0, 2'h1, 3'h0, 7'h00, 2'h2);
		req(1'h1, 2'h2, 3'h0, 7'h00, 2'h3);
		tick;
		chk({xmem_addr_bus, ymem_addr_bus} == {24'h123456, 24'h654321}, 24'h1);
		req(1'h0, 2'h1, 3'h0, 7'h00, 2'h1);
		tick;
		chk({22'h0, pv, yv}, 24'h2);
		chk(program_addr_bus, 24'h123456);
		// modulo 8 ring wraps at both ends
		wreg(2'h2, 3'h2, 24'h000007);
		rreg(2'h2, 3'h2, e);
		chk(e, 24'h000007);
		wreg(2'h0, 3'h2, 24'h000107);
		for (k = 1; k < 3; k++) begin
			req(1'h0, 2'h2, 3'(k), 7'h00, 2'h2);
			tick;
			rreg(2'h0, 3'h2, e);
			chk(e, (k == 1) ? 24'h000100 : 24'h000107);
		end
		// multiple wrap: 64K window, increment past its top wraps to its base
		wreg(2'h2, 3'h3, 24'h008000);
		wreg(2'h0, 3'h3, 24'h12FFFF);
		req(1'h0, 2'h3, 3'h1, 7'h00, 2'h2);
		tick;
		rreg(2'h0, 3'h3, e);
		chk(e, 24'h120000);
		// reverse-carry steps
		wreg(2'h2, 3'h7, 24'h000000);
		wreg(2'h1, 3'h7, n);
		for (k = 1; k < 4; k++) begin
			r = 24'($urandom);
			wreg(2'h0, 3'h7, r);
			req(1'h1, 2'h3, 3'(k), 7'h00, 2'h2);
			tick;
			rreg(2'h0, 3'h7, e);
			chk(e, rev(rev(r) + rev(step(3'(k), n, 7'h00))));
		end
		// stack pointer push then two pulls, then select Y
		wreg(2'h3, 3'h0, r);
		{wr, sop} = 3'h1;
		tick;
		sop = 2'h2;
		repeat (2) tick;
		sop = 2'h0;
		rreg(2'h3, 3'h0, e);
		chk(e, r - 24'h000001);
		chk(sad, r - 24'h000001);
		ssel = 1'h1;
		tick;
		chk({23'h0, siy}, 24'h1);
		// compat entry under stretched cycles
		wreg(2'h0, 3'h5, 24'h00CDEF);
		{wr, slow, sc} = 3'h3;
		k = 0;
		for (i = 0; i < 20 && sca !== 1'h1; i++) begin
			k += en;
			tick;
		end
		chk(24'(k), 24'h000003);
		slow = 1'h0;
		tick;
		wreg(2'h1, 3'h5, 24'hABFFFE);
		rreg(2'h1, 3'h5, e);
		chk(e, 24'h00FFFE);
		req(1'h1, 2'h1, 3'h3, 7'h00, 2'h3);
		tick;
		chk(ymem_addr_bus, 24'h00CDEF);
		req(1'h1, 2'h1, 3'h7, 7'h40, 2'h3);
		tick;
		chk(ymem_addr_bus, 24'h00CDAD);
		rreg(2'h0, 3'h5, e);
		chk(e, 24'h00CDED);
		chk(sad, {8'h00, 16'(r - 24'h000001)});
		sc = 1'h0;
		repeat (4) tick;
		chk({23'h0, sca}, 24'h0);
		close_out;
	end
endmodule
